// ==== iac_pkg.sv ====
/*
 * constants, register map and state type for the interrupt acceptance control block.
 * assumes a 32-bit apb register bus and a cpu core that answers the exception sequence.
 */
package iac_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] OFS_SYSCTL = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_EXTST = 8'h08;
    localparam logic [7:0] OFS_ENABLE = 8'h0c;
    localparam logic [7:0] OFS_PRIO = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int MODE_LO_BIT = 0;
    localparam int MODE_HI_BIT = 1;
    localparam logic [1:0] MODE_0 = 2'h0;
    localparam logic [1:0] MODE_2 = 2'h2;
    localparam int FLAG_I_BIT = 7;
    localparam int EXT_T_BIT = 7;
    localparam int LVL_W = 3;
    localparam int PRIO_FIELD_W = 4;
    localparam logic [2:0] LVL_NMI = 3'h7;
    localparam logic [7:0] FLAGS_RST = 8'h80;
    localparam logic [7:0] EXTST_RST = 8'h07;
    localparam logic [31:0] PRIO_RST = 32'h77777777;
    localparam logic [1:0] SYSCTL_RST = 2'h0;
    localparam int STAT_NMI_BIT = 8;
    localparam int STAT_BUSY_BIT = 9;
    localparam int STAT_VEC_LSB = 16;
    localparam int VEC_W = 8;
    localparam int VEC_ADDR_SHIFT = 2;

    // ****************************************
    // sequence timing in clock states
    // ****************************************
    localparam logic [1:0] PRIO_EXT_STATES = 2'h3;
    localparam logic [1:0] PRIO_INT_STATES = 2'h2;
    localparam logic [1:0] STACK_MODE0 = 2'h2;
    localparam logic [1:0] STACK_MODE2 = 2'h3;
    localparam logic [1:0] BLOCK_STATES = 2'h3;

    typedef enum logic [2:0] {
        S_IDLE,
        S_PRIO,
        S_WAIT_INSN,
        S_INT1,
        S_STACK,
        S_VECT,
        S_INT2
    } iac_state_type;

endpackage

// ==== iac_top.sv ====
/*
 * interrupt acceptance control: arbitration, masking and exception sequence control.
 * assumes apb master on clk, request inputs synchronous to clk, cpu core answering
 * the accept strobe at an instruction boundary and vector fetch with vec_ack.
 */
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module iac_top
    import iac_pkg::*;
#(
    parameter int NUM_SRC = 8,
    parameter logic [NUM_SRC-1:0] EXT_SRC_MASK = '0,
    parameter logic [7:0] NMI_VECTOR = 8'h07,
    parameter logic [7:0] SRC_VEC_BASE = 8'h10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_SRC-1:0] src_req,
    input wire logic nmi_req,
    input wire logic hw_standby,
    input wire logic insn_boundary,
    input wire logic [31:0] resume_pc,
    input wire logic vec_ack,
    input wire logic [31:0] vec_data,
    output logic accept_strobe,
    output logic [7:0] accept_vector,
    output logic stack_push,
    output logic [1:0] stack_idx,
    output logic [31:0] stack_data,
    output logic vec_fetch,
    output logic [31:0] vec_addr,
    output logic handler_start,
    output logic [31:0] handler_addr
);
    localparam int IDX_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

    // ****************************************
    // registers and state
    // ****************************************
    logic [1:0] system_control_reg;
    logic [7:0] cpu_flags_reg;
    logic [7:0] extended_status_reg;
    logic [NUM_SRC-1:0] enable_reg;
    logic [31:0] priority_setting_reg;
    logic [NUM_SRC-1:0] pend;
    logic nmi_pend;
    iac_state_type state;
    logic [1:0] cnt;
    logic [1:0] block_cnt;
    logic acc_nmi;
    logic [LVL_W-1:0] acc_lvl;
    logic [7:0] acc_vec;
    logic acc_ext;
    logic [31:0] status_word;
    logic [31:0] read_word;
    logic sel_found;
    logic [IDX_W-1:0] sel_idx;
    logic [LVL_W-1:0] sel_lvl;
    logic maskable_ok;
    logic nmi_ok;
    logic accept_go;
    logic wr_en;
    logic mapped;
    logic mask_write;
    logic stack_last;
    logic is_mode2;
    logic [2:0] mask_level_field;

    assign is_mode2 = system_control_reg[MODE_HI_BIT];
    assign mask_level_field = extended_status_reg[LVL_W-1:0];

    // ****************************************
    // apb slave
    // ****************************************
    always_comb begin
        mapped = (paddr == OFS_SYSCTL) || (paddr == OFS_FLAGS) || (paddr == OFS_EXTST) ||
                 (paddr == OFS_ENABLE) || (paddr == OFS_PRIO) || (paddr == OFS_STATUS);
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr_en = psel && penable && pwrite && mapped;
    assign mask_write = wr_en && ((paddr == OFS_FLAGS) || (paddr == OFS_EXTST));

    always_comb begin
        status_word = '0;
        status_word[NUM_SRC-1:0] = pend;
        status_word[STAT_NMI_BIT] = nmi_pend;
        status_word[STAT_BUSY_BIT] = (state != S_IDLE);
        status_word[STAT_VEC_LSB +: VEC_W] = acc_vec;
    end

    always_comb begin
        read_word = '0;
        unique case (paddr)
            OFS_SYSCTL: read_word[1:0] = system_control_reg;
            OFS_FLAGS: read_word[7:0] = cpu_flags_reg;
            OFS_EXTST: read_word[7:0] = extended_status_reg;
            OFS_ENABLE: read_word[NUM_SRC-1:0] = enable_reg;
            OFS_PRIO: read_word = priority_setting_reg;
            OFS_STATUS: read_word = status_word;
            default: read_word = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (psel && !penable) begin
            prdata <= read_word;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            system_control_reg <= SYSCTL_RST;
        end else if (wr_en && paddr == OFS_SYSCTL) begin
            if (pwdata[1:0] == MODE_0 || pwdata[1:0] == MODE_2) begin
                system_control_reg <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable_reg <= '0;
            priority_setting_reg <= PRIO_RST;
        end else if (wr_en) begin
            if (paddr == OFS_ENABLE) begin
                enable_reg <= pwdata[NUM_SRC-1:0];
            end
            if (paddr == OFS_PRIO) begin
                priority_setting_reg <= pwdata;
            end
        end
    end

    // ****************************************
    // registered pending state
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend <= '0;
            nmi_pend <= 1'b0;
        end else begin
            pend <= src_req & enable_reg;
            nmi_pend <= nmi_req;
        end
    end

    // ****************************************
    // arbitration
    // ****************************************
    always_comb begin
        sel_found = 1'b0;
        sel_idx = '0;
        sel_lvl = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (pend[i] && (!sel_found ||
                (is_mode2 && priority_setting_reg[i*PRIO_FIELD_W +: LVL_W] > sel_lvl))) begin
                sel_found = 1'b1;
                sel_idx = IDX_W'(i);
                sel_lvl = priority_setting_reg[i*PRIO_FIELD_W +: LVL_W];
            end
        end
    end

    always_comb begin
        if (is_mode2) begin
            maskable_ok = sel_found && (sel_lvl > mask_level_field);
        end else begin
            maskable_ok = sel_found && !cpu_flags_reg[FLAG_I_BIT];
        end
    end

    assign nmi_ok = nmi_pend && !hw_standby;
    assign accept_go = (state == S_IDLE) && (block_cnt == '0) && !hw_standby &&
                       (nmi_ok || maskable_ok);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            block_cnt <= '0;
        end else if (mask_write) begin
            block_cnt <= BLOCK_STATES;
        end else if (block_cnt != '0) begin
            block_cnt <= block_cnt - 2'h1;
        end
    end

    // ****************************************
    // exception sequence
    // ****************************************
    assign stack_last = (cnt == (is_mode2 ? STACK_MODE2 : STACK_MODE0) - 2'h1);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= S_IDLE;
            cnt <= '0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (accept_go) begin
                        state <= S_PRIO;
                        cnt <= ((nmi_ok || EXT_SRC_MASK[sel_idx]) ? PRIO_EXT_STATES :
                                PRIO_INT_STATES) - 2'h1;
                    end
                end
                S_PRIO: begin
                    if (cnt == '0) begin
                        state <= S_WAIT_INSN;
                    end else begin
                        cnt <= cnt - 2'h1;
                    end
                end
                S_WAIT_INSN: begin
                    if (insn_boundary) begin
                        state <= S_INT1;
                    end
                end
                S_INT1: begin
                    state <= S_STACK;
                    cnt <= '0;
                end
                S_STACK: begin
                    if (stack_last) begin
                        state <= S_VECT;
                    end else begin
                        cnt <= cnt + 2'h1;
                    end
                end
                S_VECT: begin
                    if (vec_ack) begin
                        state <= S_INT2;
                    end
                end
                S_INT2: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_nmi <= 1'b0;
            acc_lvl <= '0;
            acc_vec <= '0;
            acc_ext <= 1'b0;
        end else if (accept_go) begin
            acc_nmi <= nmi_ok;
            acc_lvl <= sel_lvl;
            acc_ext <= nmi_ok || EXT_SRC_MASK[sel_idx];
            acc_vec <= nmi_ok ? NMI_VECTOR : SRC_VEC_BASE + 8'(sel_idx);
        end
    end

    assign accept_strobe = (state == S_WAIT_INSN);
    assign accept_vector = acc_vec;

    // ****************************************
    // stack save
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stack_push <= 1'b0;
            stack_idx <= '0;
            stack_data <= '0;
        end else begin
            stack_push <= (state == S_STACK);
            stack_idx <= cnt;
            unique case (cnt)
                2'h0: stack_data <= resume_pc;
                2'h1: stack_data <= {24'h0, cpu_flags_reg};
                default: stack_data <= {24'h0, extended_status_reg};
            endcase
        end
    end

    // ****************************************
    // mask updates
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpu_flags_reg <= FLAGS_RST;
        end else if (state == S_STACK && stack_last) begin
            cpu_flags_reg[FLAG_I_BIT] <= 1'b1;
        end else if (wr_en && paddr == OFS_FLAGS) begin
            cpu_flags_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            extended_status_reg <= EXTST_RST;
        end else if (state == S_STACK && stack_last && is_mode2) begin
            extended_status_reg[EXT_T_BIT] <= 1'b0;
            extended_status_reg[LVL_W-1:0] <= acc_nmi ? LVL_NMI : acc_lvl;
        end else if (wr_en && paddr == OFS_EXTST) begin
            extended_status_reg <= pwdata[7:0];
        end
    end

    // ****************************************
    // vector fetch and handler start
    // ****************************************
    assign vec_fetch = (state == S_VECT);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vec_addr <= '0;
            handler_addr <= '0;
            handler_start <= 1'b0;
        end else begin
            vec_addr <= 32'(acc_vec) << VEC_ADDR_SHIFT;
            handler_start <= (state == S_INT2);
            if (state == S_VECT && vec_ack) begin
                handler_addr <= vec_data;
            end
        end
    end

endmodule
`default_nettype wire

// ==== iac_cpu_model.sv ====
/* cpu core model: answers the accept strobe and the vector fetch.
   assumes clk and rst_n shared with the block, dly sets the answer delay */
`timescale 1ns/1ps
`default_nettype none
module iac_cpu_model #(
    parameter logic [31:0] RESUME = 32'h00001234
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] dly,
    input wire logic accept_strobe,
    input wire logic vec_fetch,
    input wire logic [31:0] vec_addr,
    output logic insn_boundary,
    output logic vec_ack,
    output logic [31:0] vec_data,
    output logic [31:0] resume_pc
);
    // ****
    // boundary and fetch answers
    // ****
    logic [3:0] bcnt;
    logic [3:0] vcnt;
    logic [31:0] target;
    assign resume_pc = RESUME;
    assign target = {16'h8000, vec_addr[15:0]};
    // handler address valid only beside the ack
    assign vec_data = vec_ack ? target : ~target;
    always_ff @(posedge clk) begin
        bcnt <= (!rst_n || !accept_strobe || insn_boundary) ? 4'h0 : bcnt + 4'h1;
        insn_boundary <= rst_n && accept_strobe && !insn_boundary && bcnt >= dly;
    end
    always_ff @(posedge clk) begin
        vcnt <= (!rst_n || !vec_fetch || vec_ack) ? 4'h0 : vcnt + 4'h1;
        vec_ack <= rst_n && vec_fetch && !vec_ack && vcnt >= dly;
    end
endmodule
`default_nettype wire

// ==== iac_properties.sv ====
/* checker of the sequence outputs of the interrupt acceptance block.
   assumes the top module's ports only, bound below */
`timescale 1ns/1ps
`default_nettype none
module iac_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic accept_strobe,
    input wire logic insn_boundary,
    input wire logic [7:0] accept_vector,
    input wire logic stack_push,
    input wire logic [1:0] stack_idx,
    input wire logic vec_fetch,
    input wire logic vec_ack,
    input wire logic [31:0] vec_addr,
    input wire logic [31:0] vec_data,
    input wire logic handler_start,
    input wire logic [31:0] handler_addr
);
    // ****
    // checks
    // ****
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence push_two;
        stack_push && stack_idx == 2'h0 ##1 stack_push && stack_idx == 2'h1;
    endsequence
    strobe_hold_a: assert property (accept_strobe && !insn_boundary |=> accept_strobe)
        else $error("accept strobe dropped before boundary");
    strobe_fall_a: assert property ($fell(accept_strobe) |-> $past(insn_boundary))
        else $error("strobe fell without boundary");
    stack_after_a: assert property (accept_strobe && insn_boundary |-> ##3 push_two)
        else $error("stack words not after one internal state");
    vec_addr_a: assert property (vec_fetch |-> vec_addr == {22'h0, accept_vector, 2'h0})
        else $error("vector address wrong");
    fetch_hold_a: assert property (vec_fetch && !vec_ack |=> vec_fetch && $stable(vec_addr))
        else $error("vector fetch not held");
    handler_go_a: assert property (vec_fetch && vec_ack |-> ##2 handler_start
        && handler_addr == $past(vec_data, 2))
        else $error("handler start wrong");
    start_pulse_a: assert property (handler_start |=> !handler_start && !accept_strobe)
        else $error("handler start not a pulse");
    phase_excl_a: assert property (!(accept_strobe && (vec_fetch || stack_push)))
        else $error("strobe overlaps sequence");
    vector_stable_a: assert property (accept_strobe |-> $stable(accept_vector))
        else $error("vector moved under strobe");
endmodule
bind iac_top iac_checker u_chk (.clk(clk), .rst_n(rst_n), .accept_strobe(accept_strobe),
    .insn_boundary(insn_boundary), .accept_vector(accept_vector), .stack_push(stack_push),
    .stack_idx(stack_idx), .vec_fetch(vec_fetch), .vec_ack(vec_ack), .vec_addr(vec_addr),
    .vec_data(vec_data), .handler_start(handler_start), .handler_addr(handler_addr));
`default_nettype wire

// ==== test_interrupt_acceptance_control.sv ====
/* testbench of the interrupt acceptance block with a cpu core model.
   assumes iac_pkg, iac_top, iac_cpu_model and the bound checker */
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_acceptance_control;
    import iac_pkg::*;
    // ****
    // stimulus and checks
    // ****
    typedef struct packed {
        logic [1:0] md;
        logic [7:0] fl;
        logic [7:0] ex;
        logic [31:0] pr;
        logic [7:0] en;
        logic [7:0] sr;
        logic nm;
        logic sb;
        logic [8:0] vec;
        logic [7:0] xf;
        logic [7:0] xx;
    } iac_row_type;
    localparam logic [31:0] RESUME = 32'h00001234;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, src_req = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, resume_pc, vec_data, stack_data, vec_addr;
    logic [31:0] handler_addr, rd, pc_word, fl_word, ex_word;
    logic pready, pslverr, nmi_req = 1'b0, hw_standby = 1'b0, insn_boundary, vec_ack;
    logic accept_strobe, stack_push, vec_fetch, handler_start, err, hit;
    logic [7:0] accept_vector;
    logic [1:0] stack_idx;
    logic [3:0] dly = 4'h0;
    int n_mismatch = 0, num_checks = 0, pushes = 0, n;
    iac_row_type row;
    iac_row_type rows [9] = '{
        '{2'h0, 8'h00, 8'h00, 32'h77777777, 8'hff, 8'h0c, 1'b0, 1'b0, 9'h112, 8'h80, 8'h00},
        '{2'h0, 8'h80, 8'h00, 32'h77777777, 8'hff, 8'h01, 1'b0, 1'b0, 9'h000, 8'h80, 8'h00},
        '{2'h0, 8'h80, 8'h00, 32'h77777777, 8'hff, 8'h00, 1'b1, 1'b0, 9'h107, 8'h80, 8'h00},
        '{2'h0, 8'h00, 8'h00, 32'h77777777, 8'h00, 8'hff, 1'b0, 1'b0, 9'h000, 8'h00, 8'h00},
        '{2'h2, 8'h00, 8'h82, 32'h03050050, 8'hff, 8'h52, 1'b0, 1'b0, 9'h111, 8'h80, 8'h05},
        '{2'h2, 8'h00, 8'h05, 32'h00005000, 8'hff, 8'h08, 1'b0, 1'b0, 9'h000, 8'h00, 8'h05},
        '{2'h2, 8'h00, 8'h87, 32'h00000000, 8'hff, 8'h00, 1'b1, 1'b0, 9'h107, 8'h80, 8'h07},
        '{2'h2, 8'h80, 8'h00, 32'h10000000, 8'hff, 8'h80, 1'b0, 1'b0, 9'h117, 8'h80, 8'h01},
        '{2'h0, 8'h80, 8'h00, 32'h77777777, 8'hff, 8'h00, 1'b1, 1'b1, 9'h000, 8'h80, 8'h00}};
    logic [31:0] rv [5] = '{32'(SYSCTL_RST), 32'(FLAGS_RST), 32'(EXTST_RST), 32'h0, PRIO_RST};
    always #2 clk = ~clk;
    iac_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_req(src_req), .nmi_req(nmi_req), .hw_standby(hw_standby),
        .insn_boundary(insn_boundary), .resume_pc(resume_pc), .vec_ack(vec_ack),
        .vec_data(vec_data), .accept_strobe(accept_strobe), .accept_vector(accept_vector),
        .stack_push(stack_push), .stack_idx(stack_idx), .stack_data(stack_data),
        .vec_fetch(vec_fetch), .vec_addr(vec_addr), .handler_start(handler_start),
        .handler_addr(handler_addr));
    iac_cpu_model #(.RESUME(RESUME)) cpu (.clk(clk), .rst_n(rst_n), .dly(dly),
        .accept_strobe(accept_strobe), .vec_fetch(vec_fetch), .vec_addr(vec_addr),
        .insn_boundary(insn_boundary), .vec_ack(vec_ack), .vec_data(vec_data),
        .resume_pc(resume_pc));
    always @(posedge clk) begin
        if (stack_push === 1'b1) begin
            pushes++;
            if (stack_idx === 2'h0) pc_word = stack_data;
            if (stack_idx === 2'h1) fl_word = stack_data;
            if (stack_idx === 2'h2) ex_word = stack_data;
        end
    end
    task automatic wrap_up;
        if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_on(input bit s, input int lim, input bit must);
        hit = 1'b0;
        n = 0;
        while (hit !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
            hit = s ? handler_start : accept_strobe;
        end
        if (must && hit !== 1'b1) begin
            n_mismatch++;
            wrap_up();
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int r = 0; r < 9; r++) begin
            row = rows[r];
            hw_standby <= row.sb;
            apb(1'b1, OFS_SYSCTL, {30'h0, row.md});
            apb(1'b1, OFS_PRIO, row.pr);
            apb(1'b1, OFS_ENABLE, {24'h0, row.en});
            apb(1'b1, OFS_FLAGS, {24'h0, row.fl});
            apb(1'b1, OFS_EXTST, {24'h0, row.ex});
            pushes = 0;
            src_req <= row.sr;
            nmi_req <= row.nm;
            wait_on(1'b0, 40, row.vec[8]);
            chk("accepted", 32'(row.vec[8]), 32'(hit));
            src_req <= 8'h00;
            nmi_req <= 1'b0;
            if (hit === 1'b1) begin
                chk("vector", 32'(row.vec[7:0]), 32'(accept_vector));
                chk("decision time", row.nm ? 32'h7 : 32'h6, n);
                wait_on(1'b1, 80, 1'b1);
                chk("stack words", (row.md == MODE_2) ? 3 : 2, pushes);
                chk("saved pc", RESUME, pc_word);
                chk("saved flags", 32'(row.fl), fl_word);
                if (row.md == MODE_2) chk("saved status", 32'(row.ex), ex_word);
                chk("handler", {16'h8000, 6'h0, row.vec[7:0], 2'h0}, handler_addr);
            end
            apb(1'b0, OFS_FLAGS, 32'h0);
            chk("flags", 32'(row.xf), rd);
            apb(1'b0, OFS_EXTST, 32'h0);
            chk("extended status", 32'(row.xx), rd);
        end
        hw_standby <= 1'b0;
        dly <= 4'h5;
        apb(1'b1, OFS_SYSCTL, 32'h0);
        apb(1'b1, OFS_FLAGS, 32'h80);
        src_req <= 8'h08;
        wait_on(1'b0, 8, 1'b0);
        chk("masked", 32'h0, 32'(hit));
        apb(1'b1, OFS_FLAGS, 32'h0);
        wait_on(1'b0, 40, 1'b1);
        chk("blackout", 32'h6, n);
        chk("pending vector", 32'h13, 32'(accept_vector));
        src_req <= 8'h00;
        wait_on(1'b1, 80, 1'b1);
        for (int m = 1; m < 4; m += 2) begin
            apb(1'b1, OFS_SYSCTL, 32'h2);
            apb(1'b1, OFS_SYSCTL, 32'(m));
            apb(1'b0, OFS_SYSCTL, 32'h0);
            chk("mode", 32'h2, rd);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            apb(1'b0, 8'(k * 4), 32'h0);
            chk("reset value", rv[k], rd);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
